/* hw/flash_iap_program_erase.sv */
// in-application program and erase sequencer for the program flash
`timescale 1ns/1ps
`include "flash_iap_consts.svh"
// Overview of operation
// - program flash spans 32K bytes, 0000h to 7FFFh, in sectors
// - last byte is the configuration word, copied out after every reset
// - 0000h to 007Fh hold reset and interrupt vectors
// - 7A00h to 7DFFh is the area programmable in application
// - checksum bytes sit at 7FF0h low and 7FF1h high
// - armed store to 7B2Dh or 7D69h erases that 512-byte page
// - an erased page reads all ones
// - requests accepted only with key 65h and matching arm code
// - lower page: 4Ah arms a byte write, BAh a page erase
// - upper page: 4Ch arms a byte write, BCh a page erase
// - armed store writes working register byte at data pointer, 7A00h-7DFEh
// - stores outside 7A00h-7DFFh are refused
// - byte write takes 20 us, page erase 2 ms
// - cpu waits during the operation, peripherals keep running
// - interrupts stay pending through the stall, served afterwards
// - a time-out releases the cpu from a stuck write
// - programmable area reads by code read with no arming
// - time-out flag set by hardware, cleared when arm register gets zero
// - two-bit select: off, 0.8 ms, 3.2 ms or 6.4 ms watchdog
// - command register bit 0 reads whether sectors are open
module flash_iap_program_erase #(
	parameter int ERASE_CYCLES = `ERASE_TIME_MS * 1000 * `MCLK_MHZ,
	parameter int TO1_CYCLES = `TO1_TIME_US * `MCLK_MHZ,
	parameter int TO2_CYCLES = `TO2_TIME_US * `MCLK_MHZ,
	parameter int TO3_CYCLES = `TO3_TIME_US * `MCLK_MHZ
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// register writes from the cpu
	input wire logic CMD_WR,
	input wire logic ARM_WR,
	input wire flash_iap_pkg::byte_t SFR_WDATA,
	input wire logic [1:0] TIMEOUT_SEL,
	// store instruction
	input wire logic STORE_REQ,
	input wire flash_iap_pkg::addr_t DATA_PTR,
	input wire flash_iap_pkg::byte_t WORK_A,
	// flash macro condition
	input wire logic WRITE_FAULT,
	// code read path
	input wire flash_iap_pkg::addr_t CODE_ADDR,
	output flash_iap_pkg::byte_t CODE_DATA,
	output flash_iap_pkg::addr_t ROM_ADDR,
	input wire flash_iap_pkg::byte_t ROM_RDATA,
	// status and configuration
	output logic CPU_WAIT,
	output logic PROG_TIMEOUT_FLAG,
	output logic ACCESS_FLAG,
	output logic ARM_FLAG,
	output flash_iap_pkg::byte_t CONFIG_WORD,
	output logic [15:0] CHECKSUM
);
	import flash_iap_pkg::*;

	localparam int WRITE_CYCLES = `WRITE_TIME_US * `MCLK_MHZ;
	// reset image of the state: load phase, everything cleared
	localparam ctl_s RESET_IMAGE = '{state: ST_LOAD, step: 2'd0, cmd: 8'h00,
		arm: 8'h00, acc_flag: 1'b0, arm_flag: 1'b0, op_erase: 1'b0, op_page: 1'b0,
		op_off: 10'h000, op_data: 8'h00, timer: 24'h000000,
		wdog: 24'h000000, to_flag: 1'b0, wait_cpu: 1'b0,
		commit_wr: 1'b0, commit_er: 1'b0, rom_addr: 16'h0000,
		code_data: 8'h00, cfg: 8'h00, csum: 16'h0000};

	ctl_s st;
	ctl_s next_st;
	logic key_ok;
	logic wr0;
	logic wr1;
	logic er0;
	logic er1;
	logic go;
	logic page_hit;
	logic to_on;
	off_t rd_off;
	byte_t store_rdata;
	count_t wd_load;

	//----------------------------------------
	// request decode
	//----------------------------------------
	// key gate
	assign key_ok = (st.cmd == `SW_KEY);
	assign wr0 = st.arm == `ARM_WR0 && DATA_PTR >= `PAGE0_FIRST
		&& DATA_PTR <= `PAGE0_LAST;
	assign wr1 = st.arm == `ARM_WR1 && DATA_PTR >= `PAGE1_FIRST
		&& DATA_PTR <= `PAGE1_WR_LAST;
	assign er0 = st.arm == `ARM_ER0 && DATA_PTR == `ERASE0_ADDR;
	assign er1 = st.arm == `ARM_ER1 && DATA_PTR == `ERASE1_ADDR;
	assign go = STORE_REQ && key_ok && (wr0 || wr1 || er0 || er1);

	// watchdog length per select, counted only once the operation time is over
	// time-out select
	always_comb begin
		case (TIMEOUT_SEL)
			2'd1: wd_load = count_t'(TO1_CYCLES);
			2'd2: wd_load = count_t'(TO2_CYCLES);
			2'd3: wd_load = count_t'(TO3_CYCLES);
			default: wd_load = '0;
		endcase
	end
	assign to_on = (TIMEOUT_SEL != 2'd0);

	//----------------------------------------
	// code read path
	//----------------------------------------
	// programmable window decode
	assign page_hit = st.rom_addr >= `IAP_FIRST && st.rom_addr <= `IAP_LAST;
	assign rd_off = off_t'(st.rom_addr - `IAP_FIRST);

	iap_page_store #(
		.DEPTH(`IAP_BYTES),
		.AW(10)
	) u_store (
		.clk(MCLK),
		.wr_en(st.commit_wr),
		.wr_off(st.op_off),
		.wr_data(st.op_data),
		.er_en(st.commit_er),
		.er_page(st.op_page),
		.rd_off(rd_off),
		.rd_data(store_rdata)
	);

	//----------------------------------------
	// sequencer
	//----------------------------------------
	// next state of the whole block
	always_comb begin
		next_st = st;
		next_st.commit_wr = 1'b0;
		next_st.commit_er = 1'b0;
		if (CMD_WR) begin
			next_st.cmd = SFR_WDATA;
		end
		if (ARM_WR) begin
			next_st.arm = SFR_WDATA;
		end
		if (ARM_WR && SFR_WDATA == `ARM_OFF) begin
			next_st.to_flag = 1'b0;
		end
		// code reads outside 7A00h-7DFFh come from the rest of flash, reads inside it from the cells
		// vectors and user code come from outside the cells
		next_st.rom_addr = CODE_ADDR;
		next_st.code_data = page_hit ? store_rdata : ROM_RDATA;
		case (st.state)
			ST_LOAD: begin
				next_st.step = st.step + 2'd1;
				case (st.step)
					2'd0: next_st.rom_addr = `CFG_WORD_ADDR;
					2'd1: begin
						next_st.rom_addr = `CSUM_LO_ADDR;
						next_st.cfg = ROM_RDATA;
					end
					2'd2: begin
						next_st.rom_addr = `CSUM_HI_ADDR;
						next_st.csum[7:0] = ROM_RDATA;
					end
					default: begin
						next_st.csum[15:8] = ROM_RDATA;
						next_st.state = ST_IDLE;
					end
				endcase
			end
			ST_IDLE: begin
				if (go) begin
					next_st.state = ST_BUSY;
					next_st.wait_cpu = 1'b1;
					next_st.op_erase = er0 || er1;
					next_st.op_page = wr1 || er1;
					next_st.op_off = off_t'(DATA_PTR - `IAP_FIRST);
					next_st.op_data = WORK_A;
					next_st.wdog = wd_load;
					if (er0 || er1) begin
						next_st.timer = count_t'(ERASE_CYCLES - 1);
					end else begin
						next_st.timer = count_t'(WRITE_CYCLES - 1);
					end
				end
			end
			ST_BUSY: begin
				// operation time runs out first, so a slow erase is never cut short
				if (st.timer != '0) begin
					next_st.timer = st.timer - count_t'(1);
				end else if (!WRITE_FAULT) begin
					next_st.state = ST_IDLE;
					next_st.wait_cpu = 1'b0;
					next_st.commit_wr = !st.op_erase;
					next_st.commit_er = st.op_erase;
				end else if (to_on && st.wdog == '0) begin
					next_st.state = ST_IDLE;
					next_st.wait_cpu = 1'b0;
					next_st.to_flag = 1'b1;
				end else if (st.wdog != '0) begin
					// watchdog counts only in the fail state
					next_st.wdog = st.wdog - count_t'(1);
				end
			end
			default: begin
				next_st.state = ST_IDLE;
				next_st.wait_cpu = 1'b0;
			end
		endcase
		next_st.acc_flag = (next_st.cmd == `SW_KEY);
		next_st.arm_flag = next_st.arm == `ARM_WR0 || next_st.arm == `ARM_WR1
			|| next_st.arm == `ARM_ER0 || next_st.arm == `ARM_ER1;
	end

	// state register
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			st <= RESET_IMAGE;
		end else begin
			st <= next_st;
		end
	end

	//----------------------------------------
	// outputs
	//----------------------------------------
	// interrupts left to the core, only fetch stalls
	assign CPU_WAIT = st.wait_cpu;
	assign PROG_TIMEOUT_FLAG = st.to_flag;
	assign ACCESS_FLAG = st.acc_flag;
	assign ARM_FLAG = st.arm_flag;
	assign CONFIG_WORD = st.cfg;
	assign CHECKSUM = st.csum;
	assign CODE_DATA = st.code_data;
	assign ROM_ADDR = st.rom_addr;

	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	sequence s_req_ok;
		st.state == ST_IDLE && go;
	endsequence

	sequence s_req_bad;
		st.state == ST_IDLE && STORE_REQ && !go;
	endsequence

	sequence s_done;
		st.commit_wr || st.commit_er;
	endsequence

	sequence s_cfg_fetch;
		ROM_ADDR == `CFG_WORD_ADDR;
	endsequence

	sequence s_cfg_taken;
		CONFIG_WORD == $past(ROM_RDATA);
	endsequence

	a_accept_key: assert property (st.state == ST_IDLE && STORE_REQ && !ACCESS_FLAG
		|=> !CPU_WAIT)
		else $error("store accepted without key");

	a_refuse_quiet: assert property (s_req_bad |=> !CPU_WAIT ##1 !CPU_WAIT)
		else $error("refused store stalled the cpu");

	a_accept_stall: assert property (s_req_ok |=> CPU_WAIT)
		else $error("accepted store did not stall");

	a_write_hold: assert property ($rose(CPU_WAIT) && !st.op_erase |-> CPU_WAIT[*8])
		else $error("write stall too short");

	a_commit_end: assert property (s_done |-> $fell(CPU_WAIT) && !$rose(PROG_TIMEOUT_FLAG))
		else $error("commit outside stall end");

	a_timeout_release: assert property ($rose(PROG_TIMEOUT_FLAG) |-> $fell(CPU_WAIT)
		&& $past(TIMEOUT_SEL) != 2'd0)
		else $error("time-out flag without release");

	a_flag_clear: assert property (ARM_WR && SFR_WDATA == `ARM_OFF
		&& st.state != ST_BUSY |=> !PROG_TIMEOUT_FLAG)
		else $error("time-out flag not cleared");

	a_access_flag: assert property (CMD_WR |=> ACCESS_FLAG == ($past(SFR_WDATA) == `SW_KEY))
		else $error("access flag wrong");

	a_erase_addr: assert property (s_req_ok ##1 st.op_erase |->
		$past(DATA_PTR) == `ERASE0_ADDR || $past(DATA_PTR) == `ERASE1_ADDR)
		else $error("erase from wrong address");

	a_erase_page: assert property (s_req_ok ##1 st.op_erase |->
		st.op_page == ($past(DATA_PTR) == `ERASE1_ADDR))
		else $error("erase aimed at the wrong page");

	// configuration word fetched right after reset
	a_config_load: assert property ($fell(SYS_RST) |=> s_cfg_fetch ##1 s_cfg_taken)
		else $error("configuration word not loaded");

	// fault keeps the cpu waiting until the watchdog
	a_fault_hold: assert property (st.state == ST_BUSY && st.timer == '0 && WRITE_FAULT
		&& !(to_on && st.wdog == '0) |=> CPU_WAIT)
		else $error("fault released the stall early");

	// escape only after the operation time, with no commit
	a_escape_late: assert property ($rose(PROG_TIMEOUT_FLAG) |-> $past(WRITE_FAULT)
		&& $past(st.timer) == '0 && !st.commit_wr && !st.commit_er)
		else $error("time-out escape too early");

	// a clean end of the stall commits the cells
	a_commit_follows: assert property ($fell(CPU_WAIT) && !$past(WRITE_FAULT) |-> s_done)
		else $error("stall ended without commit");

	a_arm_flag: assert property (ARM_WR |=> ARM_FLAG == ($past(SFR_WDATA) == `ARM_WR0
		|| $past(SFR_WDATA) == `ARM_WR1 || $past(SFR_WDATA) == `ARM_ER0
		|| $past(SFR_WDATA) == `ARM_ER1))
		else $error("arm flag wrong");
endmodule // flash_iap_program_erase

/* hw/flash_iap_consts.svh */
// constants of the in-application flash sequencer
`ifndef FLASH_IAP_CONSTS_SVH
`define FLASH_IAP_CONSTS_SVH
// program memory map
`define FLASH_FIRST_ADDR 16'h0000
`define FLASH_LAST_ADDR 16'h7fff
`define VECTOR_LAST_ADDR 16'h007f
`define EMU_RSV_FIRST 16'h6c00
`define EMU_RSV_LAST 16'h6fff
`define IAP_FIRST 16'h7a00
`define IAP_LAST 16'h7dff
`define PAGE0_FIRST 16'h7a00
`define PAGE0_LAST 16'h7bff
`define PAGE1_FIRST 16'h7c00
`define PAGE1_WR_LAST 16'h7dfe
`define ERASE0_ADDR 16'h7b2d
`define ERASE1_ADDR 16'h7d69
`define CSUM_LO_ADDR 16'h7ff0
`define CSUM_HI_ADDR 16'h7ff1
`define CFG_WORD_ADDR 16'h7fff
`define PAGE_BYTES 512
`define IAP_BYTES 1024
// keys and arm codes
`define SW_KEY 8'h65
`define ARM_WR0 8'h4a
`define ARM_WR1 8'h4c
`define ARM_ER0 8'hba
`define ARM_ER1 8'hbc
`define ARM_OFF 8'h00
`define ERASED_BYTE 8'hff
// timing
`define MCLK_MHZ 200
`define WRITE_TIME_US 20
`define ERASE_TIME_MS 2
`define TO1_TIME_US 800
`define TO2_TIME_US 3200
`define TO3_TIME_US 6400
`endif

/* hw/flash_iap_pkg.sv */
// types of the in-application flash sequencer
package flash_iap_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] addr_t;
	typedef logic [9:0] off_t;
	typedef logic [23:0] count_t;
	typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BUSY} fsm_state_e;
	typedef struct packed {
		fsm_state_e state;
		logic [1:0] step;
		byte_t cmd;
		byte_t arm;
		logic acc_flag;
		logic arm_flag;
		logic op_erase;
		logic op_page;
		off_t op_off;
		byte_t op_data;
		count_t timer;
		count_t wdog;
		logic to_flag;
		logic wait_cpu;
		logic commit_wr;
		logic commit_er;
		addr_t rom_addr;
		byte_t code_data;
		byte_t cfg;
		logic [15:0] csum;
	} ctl_s;
endpackage

/* hw/iap_page_store.sv */
// cell array of the two programmable flash pages
`timescale 1ns/1ps
`include "flash_iap_consts.svh"
module iap_page_store #(
	parameter int DEPTH = `IAP_BYTES,
	parameter int AW = 10
) (
	input wire logic clk,
	// program port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_off,
	input wire logic [7:0] wr_data,
	// erase port
	input wire logic er_en,
	input wire logic er_page,
	// read port
	input wire logic [AW-1:0] rd_off,
	output logic [7:0] rd_data
);
	// nonvolatile cells, so no reset
	logic [7:0] mem [DEPTH];

	// read needs no arming
	assign rd_data = mem[rd_off];

	// one cell per entry: erase sets ones, program only clears bits
	for (genvar i = 0; i < DEPTH; i++) begin : g_cell
		localparam logic [AW-1:0] IDX = AW'(i);
		always_ff @(posedge clk) begin
			if (er_en && IDX[AW-1] == er_page) begin
				mem[i] <= `ERASED_BYTE;
			end else if (wr_en && wr_off == IDX) begin
				mem[i] <= mem[i] & wr_data;
			end
		end
	end
endmodule // iap_page_store

/* dv/outside_flash_model.sv */
// behavioural model of the program flash outside the programmable pages
`timescale 1ns/1ps
module outside_flash_model #(
	parameter flash_iap_pkg::byte_t CFG_VAL = 8'ha5,
	parameter flash_iap_pkg::byte_t CS_LO = 8'h3c,
	parameter flash_iap_pkg::byte_t CS_HI = 8'hc3
) (
	// read port
	input wire flash_iap_pkg::addr_t addr,
	output flash_iap_pkg::byte_t data
);
	import flash_iap_pkg::*;
	always_comb begin
		case (addr)
			16'h7fff: data = CFG_VAL;
			16'h7ff0: data = CS_LO;
			16'h7ff1: data = CS_HI;
			default: data = addr[7:0] ^ addr[15:8]; // address pattern elsewhere
		endcase
	end
endmodule // outside_flash_model

/* dv/flash_iap_program_erase_tb.sv */
// self-checking testbench of the flash program and erase sequencer
`timescale 1ns/1ps
`include "flash_iap_consts.svh"
module flash_iap_program_erase_tb;
	import flash_iap_pkg::*;
	localparam byte_t CFG_VAL = 8'h96;
	localparam byte_t CS_LO = 8'h1e;
	localparam byte_t CS_HI = 8'he1;
	logic MCLK = 1'b0, SYS_RST = 1'b1, CMD_WR = 1'b0, ARM_WR = 1'b0;
	logic STORE_REQ = 1'b0, WRITE_FAULT = 1'b0;
	logic [1:0] TIMEOUT_SEL = 2'h0;
	byte_t SFR_WDATA = 8'h00, WORK_A = 8'h00, CODE_DATA, ROM_RDATA, CONFIG_WORD;
	addr_t DATA_PTR = 16'h0000, CODE_ADDR = 16'h0000, ROM_ADDR;
	logic CPU_WAIT, PROG_TIMEOUT_FLAG, ACCESS_FLAG, ARM_FLAG;
	logic [15:0] CHECKSUM;
	int n_errors = 0;
	int checks_done = 0;
	int n;
	byte_t d;
	addr_t bad_a[5] = '{16'h7c10, 16'h7dff, 16'h7b2e, 16'h79ff, 16'h7e00};
	byte_t bad_k[5] = '{`ARM_WR0, `ARM_WR1, `ARM_ER0, `ARM_WR0, `ARM_WR1};
	// stuck write: full write time, then the watchdog length
	int to_len[4] = '{0, 4100, 4200, 4300};
	// clock, 5 ns period
	always #2.5 MCLK = ~MCLK;
	flash_iap_program_erase #(.ERASE_CYCLES(50), .TO1_CYCLES(100), .TO2_CYCLES(200),
		.TO3_CYCLES(300)) uut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CMD_WR(CMD_WR),
		.ARM_WR(ARM_WR), .SFR_WDATA(SFR_WDATA), .TIMEOUT_SEL(TIMEOUT_SEL),
		.STORE_REQ(STORE_REQ), .DATA_PTR(DATA_PTR), .WORK_A(WORK_A),
		.WRITE_FAULT(WRITE_FAULT), .CODE_ADDR(CODE_ADDR), .CODE_DATA(CODE_DATA),
		.ROM_ADDR(ROM_ADDR), .ROM_RDATA(ROM_RDATA), .CPU_WAIT(CPU_WAIT),
		.PROG_TIMEOUT_FLAG(PROG_TIMEOUT_FLAG), .ACCESS_FLAG(ACCESS_FLAG),
		.ARM_FLAG(ARM_FLAG), .CONFIG_WORD(CONFIG_WORD), .CHECKSUM(CHECKSUM));
	outside_flash_model #(.CFG_VAL(CFG_VAL), .CS_LO(CS_LO), .CS_HI(CS_HI)) rom (
		.addr(ROM_ADDR), .data(ROM_RDATA));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one register write pulse: arm register or command register
	task automatic sfr(input logic arm, input byte_t v);
		@(posedge MCLK);
		#1 CMD_WR = !arm;
		ARM_WR = arm;
		SFR_WDATA = v;
		@(posedge MCLK);
		#1 CMD_WR = 1'b0;
		ARM_WR = 1'b0;
	endtask
	// store pulse, then count stalled cycles
	task automatic store(input addr_t a, input byte_t v, output int cnt);
		@(posedge MCLK);
		#1 STORE_REQ = 1'b1;
		DATA_PTR = a;
		WORK_A = v;
		@(posedge MCLK);
		#1 STORE_REQ = 1'b0;
		cnt = 0;
		while (CPU_WAIT === 1'b1 && cnt < 5000) begin
			cnt++;
			@(posedge MCLK);
			#1;
		end
		if (cnt >= 5000) begin
			n_errors++;
			$display("BAD %0t stall never ends", $time);
			wrap_up();
		end
	endtask
	// code read with two cycles of latency
	task automatic rd(input addr_t a, output byte_t v);
		@(posedge MCLK);
		#1 CODE_ADDR = a;
		repeat (2) @(posedge MCLK);
		#1 v = CODE_DATA;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge MCLK);
		#1 SYS_RST = 1'b0;
		repeat (6) @(posedge MCLK);
		#1;
		check(CONFIG_WORD, CFG_VAL, "config word");
		check(CHECKSUM, {CS_HI, CS_LO}, "checksum");
		rd(16'h0040, d);
		check(d, 8'h40, "vector read");
		// tests never store into the emulation reserve
		rd(`EMU_RSV_FIRST, d);
		check(d, 8'h6c, "emulation reserve read");
		$display("test reset done");
		sfr(0, `SW_KEY);
		check(ACCESS_FLAG, 1'b1, "access flag");
		// erase both pages before any write
		for (int p = 0; p < 2; p++) begin
			sfr(1, p ? `ARM_ER1 : `ARM_ER0);
			check(ARM_FLAG, 1'b1, "arm flag");
			store(p ? `ERASE1_ADDR : `ERASE0_ADDR, 8'h00, n);
			check(n, 16'd50, "erase stall");
			rd(p ? `PAGE1_FIRST : `PAGE0_FIRST, d);
			check(d, `ERASED_BYTE, "erased first");
			rd(p ? 16'h7dff : `PAGE0_LAST, d);
			check(d, `ERASED_BYTE, "erased last");
		end
		$display("test erase done");
		// software owns the low voltage reset; nothing of it reaches this block
		for (int p = 0; p < 2; p++) begin
			sfr(1, p ? `ARM_WR1 : `ARM_WR0);
			store(p ? `PAGE1_WR_LAST : `IAP_FIRST, 8'h5a, n);
			check(n, 16'd4000, "write stall");
			rd(p ? `PAGE1_WR_LAST : `IAP_FIRST, d);
			check(d, 8'h5a, "written byte");
		end
		$display("test write done");
		for (int i = 0; i < 5; i++) begin
			sfr(1, bad_k[i]);
			store(bad_a[i], 8'h00, n);
			check(n, 16'd0, "refused store");
		end
		rd(16'h7c10, d);
		check(d, `ERASED_BYTE, "other page kept");
		rd(`IAP_FIRST, d);
		check(d, 8'h5a, "no stray erase");
		sfr(0, 8'h00);
		check(ACCESS_FLAG, 1'b0, "access closed");
		sfr(1, `ARM_WR0);
		store(16'h7a01, 8'h00, n);
		check(n, 16'd0, "store without key");
		$display("test refuse done");
		sfr(0, `SW_KEY);
		WRITE_FAULT = 1'b1;
		for (int s = 1; s < 4; s++) begin
			TIMEOUT_SEL = s[1:0];
			sfr(1, `ARM_WR0);
			store(16'h7a02, 8'h00, n);
			check(n, to_len[s], "watchdog stall");
			check(PROG_TIMEOUT_FLAG, 1'b1, "timeout set");
			sfr(1, `ARM_OFF);
			check(PROG_TIMEOUT_FLAG, 1'b0, "timeout cleared");
			check(ARM_FLAG, 1'b0, "arm off");
		end
		WRITE_FAULT = 1'b0;
		TIMEOUT_SEL = 2'h0;
		rd(16'h7a02, d);
		check(d, `ERASED_BYTE, "failed write kept");
		rd(16'h7a01, d);
		check(d, `ERASED_BYTE, "keyless write kept");
		sfr(0, 8'h00);
		$display("test timeout done");
		// a second reset reloads the word, cells keep their contents
		@(posedge MCLK);
		#1 SYS_RST = 1'b1;
		repeat (2) @(posedge MCLK);
		#1 check(CONFIG_WORD, 8'h00, "config in reset");
		SYS_RST = 1'b0;
		repeat (6) @(posedge MCLK);
		#1;
		check(CONFIG_WORD, CFG_VAL, "config reloaded");
		check(CHECKSUM, {CS_HI, CS_LO}, "checksum reloaded");
		rd(`PAGE1_WR_LAST, d);
		check(d, 8'h5a, "cells survive reset");
		$display("test second reset done");
		wrap_up();
	end
endmodule // flash_iap_program_erase_tb
